//--- adc_input_select_and_code_format.v
`timescale 1ns/1ps
`include "adc_sel_fmt_consts.vh"

module adc_input_select_and_code_format #(
   parameter HAS_GAIN_STAGE = 1, // 0 models the fixed-range variant
   parameter VIN_W = 24 // Filtered input width, signed microvolts
)(
   input wire core_clk, // 20 MHz clock
   input wire rst_b, // Asynchronous reset, active low
   input wire [2:0] input_selector, // Selector field of the configuration register
   input wire [2:0] gain_stage_setting, // Gain field of the configuration register
   input wire conv_done, // One-cycle pulse: filtered value is valid
   input wire signed [VIN_W-1:0] filtered_vin, // Signed filtered input, microvolts
   output reg [1:0] positive_converter_input, // Source routed to positive input
   output reg [1:0] negative_converter_input, // Source routed to negative input
   output reg neg_to_ground, // Ground switch closed on negative input
   output reg [15:0] full_scale_range, // Active full scale in millivolts
   output reg [15:0] result_q, // Result register, two's complement
   output reg result_valid // One-cycle pulse when result_q updates
);

   // ------------------------------------------------------------
   // Input routing
   // ------------------------------------------------------------
   reg [1:0] pos_d;
   reg [1:0] neg_d;
   reg gnd_d;

   always @*
   begin
      pos_d = `SRC_IN0;
      neg_d = `SRC_IN1;
      gnd_d = 1'b0;
      case (input_selector)
         `SEL_P0_N1:
         begin
            pos_d = `SRC_IN0;
            neg_d = `SRC_IN1;
         end
         `SEL_P0_N3:
         begin
            pos_d = `SRC_IN0;
            neg_d = `SRC_IN3;
         end
         `SEL_P1_N3:
         begin
            pos_d = `SRC_IN1;
            neg_d = `SRC_IN3;
         end
         `SEL_P2_N3:
         begin
            pos_d = `SRC_IN2;
            neg_d = `SRC_IN3;
         end
         `SEL_P0_GND:
         begin
            pos_d = `SRC_IN0;
            gnd_d = 1'b1;
         end
         `SEL_P1_GND:
         begin
            pos_d = `SRC_IN1;
            gnd_d = 1'b1;
         end
         `SEL_P2_GND:
         begin
            pos_d = `SRC_IN2;
            gnd_d = 1'b1;
         end
         `SEL_P3_GND:
         begin
            pos_d = `SRC_IN3;
            gnd_d = 1'b1;
         end
         default:
         begin
            pos_d = `SRC_IN0;
            neg_d = `SRC_IN1;
            gnd_d = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Full-scale selection
   // ------------------------------------------------------------
   reg [15:0] range_d;

   always @*
   begin
      range_d = `RANGE_MV_2048;
      if (HAS_GAIN_STAGE != 0)
      begin
         case (gain_stage_setting)
            `GAIN_2_3:
            begin
               range_d = `RANGE_MV_6144;
            end
            `GAIN_1:
            begin
               range_d = `RANGE_MV_4096;
            end
            `GAIN_2:
            begin
               range_d = `RANGE_MV_2048;
            end
            `GAIN_4:
            begin
               range_d = `RANGE_MV_1024;
            end
            `GAIN_8:
            begin
               range_d = `RANGE_MV_512;
            end
            `GAIN_16:
            begin
               range_d = `RANGE_MV_256;
            end
            default:
            begin
               // The two spare codes repeat the narrowest range
               range_d = `RANGE_MV_256;
            end
         endcase
      end
      else
      begin
         range_d = `RANGE_MV_2048;
      end
   end

   // ------------------------------------------------------------
   // Full scale in microvolts
   // ------------------------------------------------------------
   // A six-entry table is cheaper than a constant multiplier on the divisor
   reg [`RANGE_UV_W-1:0] range_uv_d;

   always @*
   begin
      range_uv_d = `RANGE_UV_2048;
      case (range_d)
         `RANGE_MV_6144:
         begin
            range_uv_d = `RANGE_UV_6144;
         end
         `RANGE_MV_4096:
         begin
            range_uv_d = `RANGE_UV_4096;
         end
         `RANGE_MV_2048:
         begin
            range_uv_d = `RANGE_UV_2048;
         end
         `RANGE_MV_1024:
         begin
            range_uv_d = `RANGE_UV_1024;
         end
         `RANGE_MV_512:
         begin
            range_uv_d = `RANGE_UV_512;
         end
         `RANGE_MV_256:
         begin
            range_uv_d = `RANGE_UV_256;
         end
         default:
         begin
            range_uv_d = `RANGE_UV_2048;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Operand preparation
   // ------------------------------------------------------------
   // The divider works on magnitudes so the quotient truncates toward zero
   // for both signs, which keeps one step up and one step down symmetric.
   localparam PW = VIN_W + `SCALE_SHIFT + 1;

   wire vin_neg = filtered_vin[VIN_W-1];
   wire [PW-1:0] one_pw = {{(PW-1){1'b0}}, 1'b1};
   wire [PW-1:0] vin_ext = {{(PW-VIN_W){vin_neg}}, filtered_vin};
   wire [PW-1:0] vin_mag = vin_neg ? (~vin_ext + one_pw) : vin_ext;
   wire [PW-1:0] num = vin_mag << `SCALE_SHIFT;
   wire [PW-1:0] den = {{(PW-`RANGE_UV_W){1'b0}}, range_uv_d};

   // ------------------------------------------------------------
   // Restoring divider
   // ------------------------------------------------------------
   // One stage per quotient bit, all combinational, so the result still lands
   // one cycle after the done pulse; the long chain is fine at this clock rate.
   wire [PW:0] part_rem [0:PW];
   wire [PW:0] den_ext = {1'b0, den};
   wire [PW-1:0] mag_q;

   assign part_rem[0] = {(PW+1){1'b0}};

   // Remainder stays below the divisor, so its top bit can be dropped each stage
   genvar bit_i;
   generate
      for (bit_i = 0; bit_i < PW; bit_i = bit_i + 1)
      begin : g_div
         wire [PW:0] trial = {part_rem[bit_i][PW-1:0], num[PW-1-bit_i]};
         wire fits = (trial >= den_ext);
         assign mag_q[PW-1-bit_i] = fits;
         assign part_rem[bit_i+1] = fits ? (trial - den_ext) : trial;
      end
   endgenerate

   // ------------------------------------------------------------
   // Saturation and coding
   // ------------------------------------------------------------
   wire [PW-1:0] pos_lim = {{(PW-16){1'b0}}, `CODE_POS_FULL};
   wire [PW-1:0] neg_lim = {{(PW-17){1'b0}}, `CODE_NEG_MAG};

   wire over_pos = !vin_neg && (mag_q > pos_lim);
   wire over_neg = vin_neg && (mag_q > neg_lim);
   wire [15:0] mag_lo = mag_q[15:0];
   wire [15:0] neg_code = ~mag_lo + 16'h0001;
   reg [15:0] code_d;

   always @*
   begin
      code_d = `CODE_ZERO;
      if (over_pos)
      begin
         code_d = `CODE_POS_FULL;
      end
      else if (over_neg)
      begin
         code_d = `CODE_NEG_FULL;
      end
      else if (vin_neg)
      begin
         code_d = neg_code;
      end
      else
      begin
         code_d = mag_lo;
      end
      // A grounded negative input cannot go below zero, so a negative code is noise
      if (gnd_d && code_d[15])
      begin
         code_d = `CODE_ZERO;
      end
   end

   // ------------------------------------------------------------
   // Routing and range registers
   // ------------------------------------------------------------
   // Registered so the input switches never see decoder glitches
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         positive_converter_input <= `SRC_IN0;
         negative_converter_input <= `SRC_IN1;
         neg_to_ground <= 1'b0;
         full_scale_range <= `RANGE_MV_2048;
      end
      else
      begin
         positive_converter_input <= pos_d;
         negative_converter_input <= neg_d;
         neg_to_ground <= gnd_d;
         full_scale_range <= range_d;
      end
   end

   // ------------------------------------------------------------
   // Result register
   // ------------------------------------------------------------
   // Holds between conversions; a done pulse on every cycle is accepted
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         result_q <= `CODE_ZERO;
         result_valid <= 1'b0;
      end
      else
      begin
         result_valid <= conv_done;
         if (conv_done)
         begin
            result_q <= code_d;
         end
      end
   end

endmodule // adc_input_select_and_code_format

//--- adc_sel_fmt_checker.sv
`timescale 1ns/1ps
module adc_sel_fmt_checker #(parameter VIN_W = 24) (
   input wire core_clk, // Clock
   input wire rst_b, // Reset, active low
   input wire conv_done, // Done pulse
   input wire neg_to_ground, // Ground switch
   input wire result_valid, // Result pulse
   input wire [2:0] input_selector, // Selector field
   input wire [2:0] gain_stage_setting, // Gain field
   input wire signed [VIN_W-1:0] filtered_vin, // Filtered input
   input wire [1:0] positive_converter_input, // Positive route
   input wire [15:0] full_scale_range, // Range in mV
   input wire [15:0] result_q // Result
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   property p_valid; conv_done |=> result_valid; endproperty
   a_valid: assert property (p_valid) else $error("no result pulse");
   property p_quiet; !conv_done |=> !result_valid && $stable(result_q); endproperty
   a_quiet: assert property (p_quiet) else $error("result moved");
   property p_se;
      input_selector[2] |=> neg_to_ground && positive_converter_input == $past(input_selector[1:0]);
   endproperty
   a_se: assert property (p_se) else $error("single-ended route");
   property p_diff; !input_selector[2] |=> !neg_to_ground; endproperty
   a_diff: assert property (p_diff) else $error("ground switch");
   property p_three;
      input_selector inside {3'h1, 3'h2, 3'h3} |=>
         positive_converter_input == $past(input_selector[1:0]) - 2'h1;
   endproperty
   a_three: assert property (p_three) else $error("pair route");
   property p_range; gain_stage_setting == 3'h2 |=> full_scale_range == 16'h0800; endproperty
   a_range: assert property (p_range) else $error("full scale");
   property p_nonneg; conv_done && neg_to_ground && $stable(input_selector) |=> !result_q[15];
   endproperty
   a_nonneg: assert property (p_nonneg) else $error("negative code");
   property p_sat;
      conv_done && $past(rst_b) && $stable(gain_stage_setting) &&
         filtered_vin >= $signed({1'b0, full_scale_range}) * 32'sh0000_03E8 |=> result_q == 16'h7FFF;
   endproperty
   a_sat: assert property (p_sat) else $error("no clip");
   c_se: cover property (conv_done && neg_to_ground);
   c_neg: cover property (result_valid && result_q == 16'h8000);
   c_range: cover property (full_scale_range == 16'h0100);
endmodule // adc_sel_fmt_checker
bind adc_input_select_and_code_format adc_sel_fmt_checker #(.VIN_W(VIN_W)) u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .conv_done(conv_done), .neg_to_ground(neg_to_ground),
   .result_valid(result_valid), .input_selector(input_selector), .result_q(result_q),
   .gain_stage_setting(gain_stage_setting), .filtered_vin(filtered_vin),
   .positive_converter_input(positive_converter_input), .full_scale_range(full_scale_range));

//--- adc_sel_fmt_consts.vh
`ifndef ADC_SEL_FMT_CONSTS_VH
`define ADC_SEL_FMT_CONSTS_VH

// Input selector codes (3-bit field)
`define SEL_P0_N1 3'h0
`define SEL_P0_N3 3'h1
`define SEL_P1_N3 3'h2
`define SEL_P2_N3 3'h3
`define SEL_P0_GND 3'h4
`define SEL_P1_GND 3'h5
`define SEL_P2_GND 3'h6
`define SEL_P3_GND 3'h7

// Gain setting codes (3-bit field); codes 6 and 7 repeat the narrowest range
`define GAIN_2_3 3'h0
`define GAIN_1 3'h1
`define GAIN_2 3'h2
`define GAIN_4 3'h3
`define GAIN_8 3'h4
`define GAIN_16 3'h5

// Full-scale range in millivolts
`define RANGE_MV_6144 16'h1800
`define RANGE_MV_4096 16'h1000
`define RANGE_MV_2048 16'h0800
`define RANGE_MV_1024 16'h0400
`define RANGE_MV_512 16'h0200
`define RANGE_MV_256 16'h0100

// Full-scale range in microvolts, the divisor of the code scaling
`define RANGE_UV_W 24
`define RANGE_UV_6144 24'h5D_C000
`define RANGE_UV_4096 24'h3E_8000
`define RANGE_UV_2048 24'h1F_4000
`define RANGE_UV_1024 24'h0F_A000
`define RANGE_UV_512 24'h07_D000
`define RANGE_UV_256 24'h03_E800

// Analog source index codes
`define SRC_IN0 2'h0
`define SRC_IN1 2'h1
`define SRC_IN2 2'h2
`define SRC_IN3 2'h3

// Code limits, scale shift and reset values
`define CODE_POS_FULL 16'h7FFF
`define CODE_NEG_FULL 16'h8000
`define CODE_NEG_MAG 17'h0_8000
`define CODE_ZERO 16'h0000
`define SCALE_SHIFT 15
`define SEL_RESET 3'h0
`define GAIN_RESET 3'h2

`endif

//--- analog_src_model.sv
`timescale 1ns/1ps
// Filtered source; shows junk outside the done pulse so stale data is caught
module analog_src_model (
   input wire clk, // Clock
   input wire rst_b, // Reset
   input wire req, // Convert now
   input wire [23:0] uv, // Input, microvolts
   output reg done, // Done pulse
   output reg [23:0] vin // Filtered input
);
   always @(posedge clk or negedge rst_b)
      if (!rst_b)
         {done, vin} <= 25'h000_0000;
      else
         {done, vin} <= {req, req ? uv : ~vin};
endmodule // analog_src_model

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module testbench;
   reg clk = 1'b0, rst_b = 1'b0, req = 1'b0;
   reg [2:0] sel = 3'h0, gain = 3'h2;
   reg [23:0] uv = 24'h00_0000;
   wire cd, gs, rv;
   wire [23:0] vin;
   wire [1:0] pos, neg;
   wire [15:0] rng, res, rng_fix, res_fix;
   integer miscompares = 0, n_checks = 0, k, i;
   reg [15:0] ft [0:7] = '{16'h1800, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100,
      16'h0100, 16'h0100};
   always #25 clk = ~clk;
   analog_src_model u_src (.clk(clk), .rst_b(rst_b), .req(req), .uv(uv), .done(cd), .vin(vin));
   adc_input_select_and_code_format u_dut (.core_clk(clk), .rst_b(rst_b), .input_selector(sel),
      .gain_stage_setting(gain), .conv_done(cd), .filtered_vin(vin), .positive_converter_input(pos),
      .negative_converter_input(neg), .neg_to_ground(gs), .full_scale_range(rng), .result_q(res),
      .result_valid(rv));
   adc_input_select_and_code_format #(.HAS_GAIN_STAGE(0)) u_dut_fixed (.core_clk(clk),
      .rst_b(rst_b), .input_selector(sel), .gain_stage_setting(gain), .conv_done(cd),
      .filtered_vin(vin), .positive_converter_input(), .negative_converter_input(),
      .neg_to_ground(), .full_scale_range(rng_fix), .result_q(res_fix), .result_valid());
   task stop_test;
      begin
         $display("checks %0d miscompares %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task cfg(input [2:0] s, input [2:0] g);
      begin
         @(posedge clk);
         sel <= s;
         gain <= g;
         repeat (2) @(posedge clk);
         @(negedge clk);
      end
   endtask
   task conv(input [23:0] v, input [15:0] e);
      begin
         @(posedge clk);
         req <= 1'b1;
         uv <= v;
         @(posedge clk);
         req <= 1'b0;
         for (i = 0; i < 6 && rv !== 1'b1; i++)
            @(negedge clk);
         if (i == 6)
         begin
            miscompares++;
            stop_test;
         end
         else
            `CHK("result", e, res)
      end
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      cfg(3'h0, 3'h2);
      conv(24'h00_003F, 16'h0001);
      conv(24'h00_0000, 16'h0000);
      conv(-24'sh00_003F, 16'hFFFF);
      conv(24'h1F_4000, 16'h7FFF);
      conv(24'h7A_1200, 16'h7FFF);
      conv(-24'sh1F_4000, 16'h8000);
      for (k = 0; k < 8; k++)
      begin
         cfg(3'h1, k[2:0]);
         `CHK("range", ft[k], rng)
         `CHK("range fixed", 16'h0800, rng_fix)
         conv(ft[k] * 16'h01F4, 16'h4000);
         `CHK("res fixed", ft[k] > 16'h0FFF ? 16'h7FFF : ft[k] * 16'h0008, res_fix)
      end
      for (k = 0; k < 8; k++)
      begin
         cfg(k[2:0], 3'h2);
         `CHK("gnd", k[2], gs)
         `CHK("pos", k[2] ? k[1:0] : (k == 0 ? 0 : k - 1), pos)
         if (!k[2]) `CHK("neg", k == 0 ? 1 : 3, neg)
         conv(-24'sh00_003F, k[2] ? 16'h0000 : 16'hFFFF);
      end
      stop_test;
   end
endmodule // testbench
